// ==== bench/fsw_camera_model.sv ====
// camera model: frames of fval with eight pixels each
`timescale 1ns/1ps
`default_nettype none
module fsw_camera_model (
   input  wire logic        clk_in,
   input  wire logic        go_in,
   input  wire logic [3:0]  frames_in,
   output logic             fval_out,
   output logic             pix_valid_out,
   output logic [31:0]      pix_data_out,
   output logic             busy_out
);
   initial {fval_out, pix_valid_out, busy_out, pix_data_out} = 35'h0;
   // data changes on every edge but the one that ends a burst, so a stale word is never mistaken for a pixel
   always begin
      @(posedge clk_in);
      if (go_in) begin
         busy_out <= 1'b1;
         repeat (frames_in) begin
            for (int c = 0; c < 20; c++) begin
               fval_out      <= (c < 12);
               pix_valid_out <= (c >= 4 && c < 12);
               pix_data_out  <= pix_data_out + 32'h0000_0001;
               @(posedge clk_in);
            end
         end
         busy_out <= 1'b0;
      end else pix_data_out <= ~pix_data_out;
   end
endmodule // fsw_camera_model
`default_nettype wire

// ==== bench/fsw_frame_seq_assertions.sv ====
// port checker for the frame sequence controller
`timescale 1ns/1ps
`default_nettype none
module fsw_frame_seq_assertions #(
   parameter int DATA_W = 32
) (
   input wire logic              ref_clk_in, rst_in, wb_cyc_in, wb_stb_in, wb_we_in,
   input wire logic [7:0]        wb_adr_in,
   input wire logic [3:0]        wb_sel_in,
   input wire logic [31:0]       wb_dat_in, wb_dat_out, frame_window_ctrl_out,
   input wire logic              wb_ack_out, pix_valid_in, pix_valid_out, seq_open_out, irq_out,
   input wire logic [DATA_W-1:0] pix_data_in, pix_data_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   // a request is taken only while ack is low
   wire logic req = wb_cyc_in && wb_stb_in && !wb_ack_out;
   property p_ack_next; req |=> wb_ack_out; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   // reset must quiet ack, window open, pixel valid and irq, so it is not disabled by itself
   property p_reset_quiet;
      disable iff (1'b0) rst_in |=> !wb_ack_out && !seq_open_out && !pix_valid_out && !irq_out;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("output active in reset");
   property p_pix_open; pix_valid_out |-> $past(seq_open_out); endproperty
   a_pix_open: assert property (p_pix_open) else $error("pixel out of window");
   property p_pix_cause; pix_valid_out |-> $past(pix_valid_in) && pix_data_out == $past(pix_data_in); endproperty
   a_pix_cause: assert property (p_pix_cause) else $error("pixel not from input");
   property p_fwc_write;
      req && wb_we_in && wb_adr_in == fsw_pkg::ADDR_FRAME_CTRL && wb_sel_in == 4'hF
         |=> frame_window_ctrl_out == ($past(wb_dat_in) & 32'h0FFF_FFFF);
   endproperty
   a_fwc_write: assert property (p_fwc_write) else $error("frame control not written");
   property p_fwc_hold; !(wb_cyc_in && wb_stb_in && wb_we_in) |=> $stable(frame_window_ctrl_out); endproperty
   a_fwc_hold: assert property (p_fwc_hold) else $error("frame control changed");
   property p_unmapped;
      req && !wb_we_in && wb_adr_in > fsw_pkg::ADDR_IRQ_MASK |=> wb_dat_out == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // fsw_frame_seq_assertions
bind fsw_frame_seq fsw_frame_seq_assertions #(.DATA_W(DATA_W)) fsw_frame_seq_assertions_i (.ref_clk_in, .rst_in,
   .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .frame_window_ctrl_out,
   .wb_ack_out, .pix_valid_in, .pix_valid_out, .seq_open_out, .irq_out, .pix_data_in, .pix_data_out);
`default_nettype wire

// ==== bench/fsw_frame_seq_tb.sv ====
// register and stream tests of the frame sequence controller
`timescale 1ns/1ps
`default_nettype none
module fsw_frame_seq_tb;
   logic        ref_clk_in = 1'b0, rst_in = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, lirq = 1'b0, go = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  nfr = 4'h0;
   logic [4:0]  trg = 5'h00;
   logic [31:0] dat = 32'h0000_0000, q, rd_dat, fwc, pd_in, pd_out;
   logic        ack, pv_in, pv_out, fval, sopen, irq, busy;
   logic [15:0] pix_cnt = 16'h0000, base;
   int          bad_count = 0, n_checks = 0, cycles = 0;
   logic [31:0] rb_exp [5] = '{32'h0FFF_FFFF, 32'hFFFF_FFFF, 32'h00FF_00FF, 32'hC000_FFFF, 32'h0FFF_FFFF};
   always #12.5 ref_clk_in = ~ref_clk_in;
   fsw_frame_seq fsw_frame_seq_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(dat), .wb_dat_out(rd_dat), .wb_ack_out(ack),
      .selected_trigger_input_in(trg[0]), .selected_encoder_a_in(trg[1]), .selected_encoder_b_in(trg[2]),
      .selected_encoder_divider_in(trg[3]), .selected_encoder_quadrature_in(trg[4]), .fval_in(fval),
      .pix_valid_in(pv_in), .pix_data_in(pd_in), .line_irq_in(lirq), .pix_valid_out(pv_out),
      .pix_data_out(pd_out), .seq_open_out(sopen), .frame_window_ctrl_out(fwc), .irq_out(irq));
   fsw_camera_model fsw_camera_model_i (.clk_in(ref_clk_in), .go_in(go), .frames_in(nfr), .fval_out(fval),
      .pix_valid_out(pv_in), .pix_data_out(pd_in), .busy_out(busy));
   // accepted pixels and the hang limit
   always @(posedge ref_clk_in) begin
      if (pv_out === 1'b1) pix_cnt <= pix_cnt + 16'h0001;
      cycles++;
      if (cycles == 30000) begin bad_count++; close_out(); end
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin bad_count++; $display("[ERR] %0t seen %h expected %h", $time, seen, exp); end
   endtask
   // one classic cycle: hold everything until ack is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
      do begin @(posedge ref_clk_in); n++; end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) bad_count++;
      q = rd_dat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge ref_clk_in);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d); xfer(1'b1, a, d); endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e); xfer(1'b0, a, 32'h0); chk(q, e); endtask
   task automatic pulse(input int n);
      repeat (n) begin lirq <= 1'b1; @(posedge ref_clk_in); lirq <= 1'b0; repeat (3) @(posedge ref_clk_in); end
   endtask
   task automatic wait_open(input logic v);
      int n = 0;
      while (sopen !== v && n < 300) begin @(posedge ref_clk_in); n++; end
      chk(sopen, v);
   endtask
   task automatic frames(input logic [3:0] n);
      go <= 1'b1; nfr <= n; @(posedge ref_clk_in); go <= 1'b0; @(posedge ref_clk_in);
      while (busy === 1'b1) @(posedge ref_clk_in);
   endtask
   initial begin
      repeat (16) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      @(posedge ref_clk_in);
      for (int i = 0; i < 9; i++) rdchk(8'(i * 4), 32'h0000_0000);
      for (int i = 0; i < 5; i++) begin
         wr(8'(i * 4), 32'hFFFF_FFFF);
         rdchk(8'(i * 4), rb_exp[i]);
      end
      chk(fwc, 32'h0FFF_FFFF);
      wr(8'h40, 32'hFFFF_FFFF);
      rdchk(8'h40, 32'h0000_0000);
      wr(fsw_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
      // line interrupt divide by three, restart and clear
      wr(fsw_pkg::ADDR_LINE_DEC, 32'h4000_0003);
      pulse(2); rdchk(fsw_pkg::ADDR_IRQ_STAT, 32'h0);
      pulse(1); rdchk(fsw_pkg::ADDR_IRQ_STAT, 32'h4);
      chk(irq, 1'b1);
      wr(fsw_pkg::ADDR_IRQ_STAT, 32'h4);
      pulse(2); rdchk(fsw_pkg::ADDR_IRQ_STAT, 32'h0);
      wr(fsw_pkg::ADDR_LINE_DEC, 32'h7000_0003);
      pulse(2); rdchk(fsw_pkg::ADDR_IRQ_STAT, 32'h0);
      pulse(1); rdchk(fsw_pkg::ADDR_IRQ_STAT, 32'h4);
      wr(fsw_pkg::ADDR_IRQ_STAT, 32'h4);
      chk(irq, 1'b0);
      wr(fsw_pkg::ADDR_LINE_DEC, 32'h8000_0003);
      pulse(1); rdchk(fsw_pkg::ADDR_IRQ_STAT, 32'h0);
      wr(fsw_pkg::ADDR_LINE_DEC, 32'h0000_0003);
      pulse(1); rdchk(fsw_pkg::ADDR_IRQ_STAT, 32'h4);
      wr(fsw_pkg::ADDR_IRQ_STAT, 32'h7);
      // immediate open, skip one frame, keep two
      wr(fsw_pkg::ADDR_SEQ_CTRL, 32'h0000_0000);
      wr(fsw_pkg::ADDR_SEQ_DIM, 32'h0001_0002);
      wr(fsw_pkg::ADDR_SEQ_DIMX, 32'h0000_0000);
      wr(fsw_pkg::ADDR_ENG_CTRL, 32'h0001_0001);
      wait_open(1'b1);
      wr(fsw_pkg::ADDR_ENG_CTRL, 32'h0000_0000);
      base = pix_cnt;
      frames(3);
      wait_open(1'b0);
      chk(32'(pix_cnt - base), 32'd16);
      rdchk(fsw_pkg::ADDR_IRQ_STAT, 32'h3);
      wr(fsw_pkg::ADDR_IRQ_STAT, 32'h3);
      // frame sync: a frame already running is not taken
      wr(fsw_pkg::ADDR_SEQ_CTRL, 32'h0100_0000);
      wr(fsw_pkg::ADDR_SEQ_DIM, 32'h0000_0001);
      base = pix_cnt;
      go <= 1'b1; nfr <= 4'h2; @(posedge ref_clk_in); go <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      wr(fsw_pkg::ADDR_ENG_CTRL, 32'h0001_0001);
      chk(sopen, 1'b0);
      wait_open(1'b1);
      wr(fsw_pkg::ADDR_ENG_CTRL, 32'h0000_0000);
      while (busy === 1'b1) @(posedge ref_clk_in);
      wait_open(1'b0);
      chk(32'(pix_cnt - base), 32'd8);
      // trigger close: the frame after the trigger is still taken
      wr(fsw_pkg::ADDR_SEQ_CTRL, 32'h0000_0100);
      wr(fsw_pkg::ADDR_ENG_CTRL, 32'h0001_0001);
      wait_open(1'b1);
      wr(fsw_pkg::ADDR_ENG_CTRL, 32'h0000_0000);
      trg <= 5'h01;
      repeat (8) @(posedge ref_clk_in);
      chk(sopen, 1'b1);
      base = pix_cnt;
      frames(1);
      wait_open(1'b0);
      chk(32'(pix_cnt - base), 32'd8);
      // trigger open: each source with its own condition
      for (int i = 0; i < 5; i++) begin
         logic [4:0] idle;
         idle = (i == 1 || i == 3) ? 5'h1F : 5'h00;
         trg <= idle;
         wr(fsw_pkg::ADDR_IRQ_STAT, 32'h7);
         wr(fsw_pkg::ADDR_SEQ_CTRL, 32'h0010_0000 | (32'(i) << 16) | (32'(i) << 12));
         wr(fsw_pkg::ADDR_ENG_CTRL, 32'h0001_0001);
         trg <= idle ^ ~(5'h01 << i);
         repeat (8) @(posedge ref_clk_in);
         chk(sopen, 1'b0);
         trg <= ~idle;
         wait_open(1'b1);
         wr(fsw_pkg::ADDR_ENG_CTRL, 32'h0000_0000);
         frames(1);
         wait_open(1'b0);
      end
      close_out();
   end
endmodule // fsw_frame_seq_tb
`default_nettype wire

// ==== design/fsw_frame_seq.sv ====
// frame sequence window controller with wishbone register file
`timescale 1ns/1ps
`default_nettype none

module fsw_frame_seq #(
   parameter int DATA_W = 32
) (
   input  wire logic              ref_clk_in,
   input  wire logic              rst_in,
   // wishbone slave
   input  wire logic              wb_cyc_in,
   input  wire logic              wb_stb_in,
   input  wire logic              wb_we_in,
   input  wire logic [7:0]        wb_adr_in,
   input  wire logic [3:0]        wb_sel_in,
   input  wire logic [31:0]       wb_dat_in,
   output logic      [31:0]       wb_dat_out,
   output logic                   wb_ack_out,
   // trigger, encoder and frame valid pins
   input  wire logic              selected_trigger_input_in,
   input  wire logic              selected_encoder_a_in,
   input  wire logic              selected_encoder_b_in,
   input  wire logic              selected_encoder_divider_in,
   input  wire logic              selected_encoder_quadrature_in,
   input  wire logic              fval_in,
   // camera stream, already on this clock
   input  wire logic              pix_valid_in,
   input  wire logic [DATA_W-1:0] pix_data_in,
   input  wire logic              line_irq_in,
   // outputs
   output logic                   pix_valid_out,
   output logic      [DATA_W-1:0] pix_data_out,
   output logic                   seq_open_out,
   output logic      [31:0]       frame_window_ctrl_out,
   output logic                   irq_out
);

   logic [31:0] seq_ctrl_ff, seq_dim_ff, seq_dimx_ff, line_dec_ff, frame_ctrl_ff, eng_ctrl_ff;
   logic [fsw_pkg::IRQ_BITS-1:0] irq_stat_ff, irq_mask_ff;
   logic [4:0]  src_meta_ff, src_sync_ff, src_prev_ff;
   logic        fval_meta_ff, fval_sync_ff, fval_prev_ff;
   logic        in_frame_ff;
   fsw_pkg::fsw_state_e state_ff, nxt_state;
   logic [23:0] frame_cnt_ff;
   logic [15:0] volume_cnt_ff;
   logic [15:0] dec_cnt_ff;
   logic        close_armed_ff;
   logic        run_prev_ff;

   // byte-lane merge for wishbone writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // conditioning shared by open and close paths
   function automatic logic trig_met(input logic [3:0] cond, input logic cur, input logic prev);
      logic r;
      r = 1'b0;
      case (cond)
         fsw_pkg::COND_RISE:   r = cur & ~prev;
         fsw_pkg::COND_FALL:   r = ~cur & prev;
         fsw_pkg::COND_HIGH:   r = cur;
         fsw_pkg::COND_LOW:    r = ~cur;
         fsw_pkg::COND_EITHER: r = cur ^ prev;
         default:              r = 1'b0;   // undefined codes never fire
      endcase
      return r;
   endfunction

   // source index, unknown codes select nothing
   function automatic logic src_pick(input logic [3:0] sel, input logic [4:0] v);
      logic r;
      r = 1'b0;
      if (sel <= fsw_pkg::SRC_ENC_QUAD) begin
         r = v[sel[2:0]];
      end
      return r;
   endfunction

   wire logic wb_req   = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   wire logic wb_wr    = wb_req & wb_we_in;
   wire logic [4:0] src_raw = {selected_encoder_quadrature_in, selected_encoder_divider_in,
                               selected_encoder_b_in, selected_encoder_a_in, selected_trigger_input_in};

   // field views
   wire logic [3:0]  close_cond = seq_ctrl_ff[fsw_pkg::CLOSE_COND_LSB +: 4];
   wire logic [3:0]  close_src  = seq_ctrl_ff[fsw_pkg::CLOSE_SRC_LSB +: 4];
   wire logic [3:0]  close_mode = seq_ctrl_ff[fsw_pkg::CLOSE_MODE_LSB +: 4];
   wire logic [3:0]  open_cond  = seq_ctrl_ff[fsw_pkg::OPEN_COND_LSB +: 4];
   wire logic [3:0]  open_src   = seq_ctrl_ff[fsw_pkg::OPEN_SRC_LSB +: 4];
   wire logic [3:0]  open_mode  = seq_ctrl_ff[fsw_pkg::OPEN_MODE_LSB +: 4];
   wire logic [3:0]  sync_mode  = seq_ctrl_ff[fsw_pkg::SYNC_MODE_LSB +: 4];
   wire logic [23:0] frames_per_seq = {seq_dimx_ff[fsw_pkg::SIZE_HI_LSB +: 8],
                                       seq_dim_ff[fsw_pkg::SIZE_LO_LSB +: 16]};
   wire logic [23:0] frames_to_skip = {seq_dimx_ff[fsw_pkg::SKIP_HI_LSB +: 8],
                                       seq_dim_ff[fsw_pkg::SKIP_LO_LSB +: 16]};
   wire logic [15:0] line_irq_divide_count = line_dec_ff[fsw_pkg::DEC_COUNT_LSB +: 16];
   wire logic [1:0]  line_irq_divide_mode  = line_dec_ff[fsw_pkg::DEC_MODE_LSB +: 2];
   wire logic        run_bit   = eng_ctrl_ff[fsw_pkg::RUN_BIT];
   wire logic [15:0] volumes   = eng_ctrl_ff[fsw_pkg::VOLUME_CNT_LSB +: 16];

   // trigger pins come from outside the clock domain
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         src_meta_ff  <= 5'h00;
         src_sync_ff  <= 5'h00;
         src_prev_ff  <= 5'h00;
         fval_meta_ff <= 1'b0;
         fval_sync_ff <= 1'b0;
         fval_prev_ff <= 1'b0;
      end else begin
         src_meta_ff  <= src_raw;
         src_sync_ff  <= src_meta_ff;
         src_prev_ff  <= src_sync_ff;
         fval_meta_ff <= fval_in;
         fval_sync_ff <= fval_meta_ff;
         fval_prev_ff <= fval_sync_ff;
      end
   end

   wire logic open_hit  = trig_met(open_cond, src_pick(open_src, src_sync_ff),
                                   src_pick(open_src, src_prev_ff));
   wire logic close_hit = trig_met(close_cond, src_pick(close_src, src_sync_ff),
                                   src_pick(close_src, src_prev_ff));
   wire logic sof = fval_sync_ff & ~fval_prev_ff;
   wire logic eof = ~fval_sync_ff & fval_prev_ff;
   wire logic run_start = run_bit & ~run_prev_ff;

   // frame tracking; with sync 1, sof marks the point from which pixels count
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         in_frame_ff <= 1'b0;
         run_prev_ff <= 1'b0;
      end else begin
         run_prev_ff <= run_bit;
         if (sof) begin
            in_frame_ff <= 1'b1;
         end else if (eof) begin
            in_frame_ff <= 1'b0;
         end
      end
   end

   // open gate: in immediate open mode, sync mode 1 needs a frame start before the window opens
   wire logic sync_ok  = (sync_mode != fsw_pkg::SYNC_SOF) | sof;
   wire logic open_ok  = (open_mode == fsw_pkg::OPEN_TRIG) ? open_hit : sync_ok;
   wire logic last_vol = (volumes != fsw_pkg::VOLUME_INFINITE) & (volume_cnt_ff + 16'h0001 >= volumes);
   wire logic size_done = eof & (frame_cnt_ff + 24'h00_0001 >= frames_per_seq);

   // sequence state sequencing
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         fsw_pkg::ST_IDLE: begin
            if (run_start) begin
               nxt_state = fsw_pkg::ST_WAIT_OPEN;
            end
         end
         fsw_pkg::ST_WAIT_OPEN: begin
            if (!run_bit) begin
               nxt_state = fsw_pkg::ST_IDLE;
            end else if (open_ok) begin
               nxt_state = (frames_to_skip != 24'h00_0000) ? fsw_pkg::ST_SKIP : fsw_pkg::ST_ACQ;
            end
         end
         fsw_pkg::ST_SKIP: begin
            if (eof && (frame_cnt_ff + 24'h00_0001 >= frames_to_skip)) begin
               nxt_state = fsw_pkg::ST_ACQ;
            end
         end
         fsw_pkg::ST_ACQ: begin
            if (close_mode == fsw_pkg::CLOSE_TRIG) begin
               if (close_hit) begin
                  nxt_state = fsw_pkg::ST_CLOSING;
               end
            end else if (size_done || frames_per_seq == 24'h00_0000) begin
               nxt_state = (last_vol || !run_bit) ? fsw_pkg::ST_IDLE : fsw_pkg::ST_WAIT_OPEN;
            end
         end
         fsw_pkg::ST_CLOSING: begin
            if (eof) begin
               nxt_state = (last_vol || !run_bit) ? fsw_pkg::ST_IDLE : fsw_pkg::ST_WAIT_OPEN;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         state_ff <= fsw_pkg::ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // frame and volume counting; frame count restarts at each window phase change
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         frame_cnt_ff  <= 24'h00_0000;
         volume_cnt_ff <= 16'h0000;
      end else begin
         if (nxt_state != state_ff) begin
            frame_cnt_ff <= 24'h00_0000;
         end else if (eof && (state_ff == fsw_pkg::ST_SKIP || state_ff == fsw_pkg::ST_ACQ ||
                              state_ff == fsw_pkg::ST_CLOSING)) begin
            frame_cnt_ff <= frame_cnt_ff + 24'h00_0001;
         end
         if (state_ff == fsw_pkg::ST_IDLE) begin
            if (run_start) begin
               volume_cnt_ff <= 16'h0000;
            end
         end else if (nxt_state == fsw_pkg::ST_WAIT_OPEN && state_ff != fsw_pkg::ST_WAIT_OPEN) begin
            volume_cnt_ff <= volume_cnt_ff + 16'h0001;
         end
      end
   end

   // close_armed marks that the current frame started inside the window with sync on
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         close_armed_ff <= 1'b0;
      end else if (state_ff == fsw_pkg::ST_WAIT_OPEN && nxt_state != fsw_pkg::ST_WAIT_OPEN) begin
         close_armed_ff <= sof | (sync_mode != fsw_pkg::SYNC_SOF);
      end else if (sof) begin
         close_armed_ff <= 1'b1;
      end else if (eof && sync_mode == fsw_pkg::SYNC_SOF) begin
         close_armed_ff <= 1'b0;
      end
   end

   wire logic acquiring = (state_ff == fsw_pkg::ST_ACQ) | (state_ff == fsw_pkg::ST_CLOSING);
   // sync 0 takes all data in acquire and closing; sync 1 needs the frame start seen
   wire logic pix_take = acquiring & pix_valid_in &
                         ((sync_mode == fsw_pkg::SYNC_SOF) ? (close_armed_ff & in_frame_ff) : 1'b1);

   // registered pixel stream
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         pix_valid_out <= 1'b0;
         pix_data_out  <= '0;
      end else begin
         pix_valid_out <= pix_take;
         if (pix_take) begin
            pix_data_out <= pix_data_in;
         end
      end
   end

   wire logic dec_clear_wr = wb_wr & (wb_adr_in == fsw_pkg::ADDR_LINE_DEC) & wb_sel_in[3] &
                             (wb_dat_in[fsw_pkg::DEC_CLEAR_LSB +: 2] != 2'b00);
   // decimation: count 0 or 1 behaves as pass-through
   wire logic dec_hit = line_irq_in & (dec_cnt_ff + 16'h0001 >= line_irq_divide_count);
   logic line_event;
   always_comb begin
      unique case (line_irq_divide_mode)
         fsw_pkg::DEC_PASS:   line_event = line_irq_in;
         fsw_pkg::DEC_DIVIDE: line_event = dec_hit;
         default:             line_event = 1'b0;  // reserved modes stay quiet
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         dec_cnt_ff <= 16'h0000;
      end else if (dec_clear_wr) begin
         dec_cnt_ff <= 16'h0000;
      end else if (line_irq_divide_mode == fsw_pkg::DEC_DIVIDE && line_irq_in) begin
         dec_cnt_ff <= dec_hit ? 16'h0000 : dec_cnt_ff + 16'h0001;
      end
   end

   wire logic open_evt  = (state_ff == fsw_pkg::ST_WAIT_OPEN) & (nxt_state != fsw_pkg::ST_WAIT_OPEN) &
                          (nxt_state != fsw_pkg::ST_IDLE);
   wire logic close_evt = acquiring & ~(nxt_state == fsw_pkg::ST_ACQ || nxt_state == fsw_pkg::ST_CLOSING);
   wire logic [fsw_pkg::IRQ_BITS-1:0] irq_set = {line_event, close_evt, open_evt};

   // register writes; the clear field is a strobe and reads back zero
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         seq_ctrl_ff   <= fsw_pkg::RST_ZERO;
         seq_dim_ff    <= fsw_pkg::RST_ZERO;
         seq_dimx_ff   <= fsw_pkg::RST_ZERO;
         line_dec_ff   <= fsw_pkg::RST_ZERO;
         frame_ctrl_ff <= fsw_pkg::RST_ZERO;
         eng_ctrl_ff   <= fsw_pkg::RST_ZERO;
         irq_mask_ff   <= '0;
      end else if (wb_wr) begin
         case (wb_adr_in)
            fsw_pkg::ADDR_SEQ_CTRL:   seq_ctrl_ff   <= lane_merge(seq_ctrl_ff, wb_dat_in, wb_sel_in) & 32'h0FFF_FFFF;
            fsw_pkg::ADDR_SEQ_DIM:    seq_dim_ff    <= lane_merge(seq_dim_ff, wb_dat_in, wb_sel_in);
            fsw_pkg::ADDR_SEQ_DIMX:   seq_dimx_ff   <= lane_merge(seq_dimx_ff, wb_dat_in, wb_sel_in) & 32'h00FF_00FF;
            fsw_pkg::ADDR_LINE_DEC:   line_dec_ff   <= lane_merge(line_dec_ff, wb_dat_in, wb_sel_in) & 32'hC000_FFFF;
            fsw_pkg::ADDR_FRAME_CTRL: frame_ctrl_ff <= lane_merge(frame_ctrl_ff, wb_dat_in, wb_sel_in) & 32'h0FFF_FFFF;
            fsw_pkg::ADDR_ENG_CTRL:   eng_ctrl_ff   <= lane_merge(eng_ctrl_ff, wb_dat_in, wb_sel_in) & 32'hFFFF_0001;
            fsw_pkg::ADDR_IRQ_MASK: begin
               if (wb_sel_in[0]) begin
                  irq_mask_ff <= wb_dat_in[fsw_pkg::IRQ_BITS-1:0];
               end
            end
            default: ;
         endcase
      end
   end

   wire logic irq_clr_wr = wb_wr & (wb_adr_in == fsw_pkg::ADDR_IRQ_STAT) & wb_sel_in[0];

   // sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         irq_stat_ff <= '0;
      end else begin
         irq_stat_ff <= (irq_stat_ff & ~(irq_clr_wr ? wb_dat_in[fsw_pkg::IRQ_BITS-1:0] : '0)) | irq_set;
      end
   end

   // one-cycle ack; unmapped reads return zero
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= fsw_pkg::RST_ZERO;
      end else begin
         wb_ack_out <= wb_req;
         if (wb_req && !wb_we_in) begin
            case (wb_adr_in)
               fsw_pkg::ADDR_SEQ_CTRL:   wb_dat_out <= seq_ctrl_ff;
               fsw_pkg::ADDR_SEQ_DIM:    wb_dat_out <= seq_dim_ff;
               fsw_pkg::ADDR_SEQ_DIMX:   wb_dat_out <= seq_dimx_ff;
               fsw_pkg::ADDR_LINE_DEC:   wb_dat_out <= line_dec_ff;
               fsw_pkg::ADDR_FRAME_CTRL: wb_dat_out <= frame_ctrl_ff;
               fsw_pkg::ADDR_ENG_CTRL:   wb_dat_out <= eng_ctrl_ff;
               fsw_pkg::ADDR_ENG_STAT:   wb_dat_out <= {frame_cnt_ff, 4'h0,
                                                        fval_sync_ff, 3'(state_ff)};
               fsw_pkg::ADDR_IRQ_STAT:   wb_dat_out <= {29'h0, irq_stat_ff};
               fsw_pkg::ADDR_IRQ_MASK:   wb_dat_out <= {29'h0, irq_mask_ff};
               default:                  wb_dat_out <= fsw_pkg::RST_ZERO;
            endcase
         end
      end
   end

   assign seq_open_out          = (state_ff != fsw_pkg::ST_IDLE) & (state_ff != fsw_pkg::ST_WAIT_OPEN);
   assign frame_window_ctrl_out = frame_ctrl_ff;
   assign irq_out               = |(irq_stat_ff & irq_mask_ff);

endmodule // fsw_frame_seq

`default_nettype wire

// ==== inc/fsw_pkg.sv ====
// constants for the frame sequence window controller
package fsw_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_SEQ_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_SEQ_DIM    = 8'h04;
   localparam logic [7:0] ADDR_SEQ_DIMX   = 8'h08;
   localparam logic [7:0] ADDR_LINE_DEC   = 8'h0C;
   localparam logic [7:0] ADDR_FRAME_CTRL = 8'h10;
   localparam logic [7:0] ADDR_ENG_CTRL   = 8'h14;
   localparam logic [7:0] ADDR_ENG_STAT   = 8'h18;
   localparam logic [7:0] ADDR_IRQ_STAT   = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_MASK   = 8'h20;
   // sequence control field positions
   localparam int CLOSE_COND_LSB = 0;
   localparam int CLOSE_SRC_LSB  = 4;
   localparam int CLOSE_MODE_LSB = 8;
   localparam int OPEN_COND_LSB  = 12;
   localparam int OPEN_SRC_LSB   = 16;
   localparam int OPEN_MODE_LSB  = 20;
   localparam int SYNC_MODE_LSB  = 24;
   // dimension field positions
   localparam int SIZE_LO_LSB = 0;
   localparam int SKIP_LO_LSB = 16;
   localparam int SIZE_HI_LSB = 0;
   localparam int SKIP_HI_LSB = 16;
   // decimation register fields
   localparam int DEC_COUNT_LSB = 0;
   localparam int DEC_CLEAR_LSB = 28;
   localparam int DEC_MODE_LSB  = 30;
   // engine control fields
   localparam int RUN_BIT        = 0;
   localparam int VOLUME_CNT_LSB = 16;
   localparam logic [15:0] VOLUME_INFINITE = 16'hFFFF;
   // trigger conditions
   localparam logic [3:0] COND_RISE   = 4'h0;
   localparam logic [3:0] COND_FALL   = 4'h1;
   localparam logic [3:0] COND_HIGH   = 4'h2;
   localparam logic [3:0] COND_LOW    = 4'h3;
   localparam logic [3:0] COND_EITHER = 4'h4;
   // trigger sources
   localparam logic [3:0] SRC_TRIGGER = 4'h0;
   localparam logic [3:0] SRC_ENC_A   = 4'h1;
   localparam logic [3:0] SRC_ENC_B   = 4'h2;
   localparam logic [3:0] SRC_ENC_DIV = 4'h3;
   localparam logic [3:0] SRC_ENC_QUAD = 4'h4;
   // modes
   localparam logic [3:0] CLOSE_SIZE   = 4'h0;
   localparam logic [3:0] CLOSE_TRIG   = 4'h1;
   localparam logic [3:0] OPEN_IMMED   = 4'h0;
   localparam logic [3:0] OPEN_TRIG    = 4'h1;
   localparam logic [3:0] SYNC_NONE    = 4'h0;
   localparam logic [3:0] SYNC_SOF     = 4'h1;
   localparam logic [1:0] DEC_PASS     = 2'h0;
   localparam logic [1:0] DEC_DIVIDE   = 2'h1;
   // interrupt status bits
   localparam int IRQ_SEQ_OPEN  = 0;
   localparam int IRQ_SEQ_CLOSE = 1;
   localparam int IRQ_LINE      = 2;
   localparam int IRQ_BITS      = 3;
   // reset values
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT_OPEN, ST_SKIP, ST_ACQ, ST_CLOSING
   } fsw_state_e;
endpackage
